// >>> inc/hbtc_pkg.sv
`default_nettype none
package hbtc_pkg;
   localparam int NCH = 24;
   localparam int CH_W = 5;
   localparam int FINE_TAPS = 32;
   localparam int FINE_W = 5;
   localparam int COARSE_W = 12;
   localparam int TIME_W = COARSE_W + FINE_W;
   localparam int WIDTH_W = 8;
   localparam int ADJ_W = 8;
   // 256 is the larger build option
   localparam int L1_DEPTH = 128;
   localparam int L1_AW = $clog2(L1_DEPTH);
   localparam int L1_CNT_W = L1_AW + 1;
   localparam int RECOVER_FREE = 4;
   localparam int HIT_FIFO_DEPTH = 16;
   localparam int TRG_FIFO_DEPTH = 8;
   localparam int TAG_W = 12;
   localparam int EVT_W = 12;
   // coarse sample chosen by the fine time's upper half
   localparam logic [FINE_W-1:0] FINE_HALF = 5'h10;
   // 6.25 ns step over a 0.78 ns bin is a shift by three
   localparam int TRAIL_SHIFT = 3;
   localparam logic [WIDTH_W-1:0] WIDTH_MAX = 8'hFF;
   // hit word layout
   localparam int HW_WIDTH_LSB = 0;
   localparam int HW_EDGE_BIT = 0;
   localparam int HW_TIME_LSB = HW_WIDTH_LSB + WIDTH_W;
   localparam int HW_CH_LSB = HW_TIME_LSB + TIME_W;
   localparam int HW_OVF_BIT = HW_CH_LSB + CH_W;
   localparam int HIT_W = HW_OVF_BIT + 1;
   // trigger word layout
   localparam int TW_TAG_LSB = 0;
   localparam int TW_EVT_LSB = TAG_W;
   localparam int TW_LOST_BIT = TAG_W + EVT_W;
   localparam int TRG_W = TW_LOST_BIT + 1;
   // reset values
   localparam logic [EVT_W-1:0] EVT_RESET = 12'h000;
   localparam logic [NCH-1:0] QUEUE_RESET = 24'h000000;
   typedef enum logic [1:0] {
      HBTC_MODE_SINGLE = 2'b00,
      HBTC_MODE_CHARGE = 2'b01,
      HBTC_MODE_TRAIL = 2'b10
   } hbtc_mode_t;
endpackage : hbtc_pkg
`default_nettype wire

// >>> rtl/hbtc_top.sv
// Contract
// [RQ1] shared hit buffer holds 128 entries, written circularly at the next location
// [RQ2] any buffer address can be read at any time by the matching logic
// [RQ3] word holds full leading time and reduced width; single-edge uses an edge bit
// [RQ4] charge mode stores width as eight bits in fine bin steps
// [RQ5] trailing mode stores width as eight bits in coarser steps
// [RQ6] serviced hit: select channel, encode fine time, pick coarse sample, append channel
// [RQ7] fixed channel priority; new requests admitted only when queue is empty
// [RQ8] the queue serves one request per clock cycle
// [RQ9] channels request only with finished width; write order is not time order
// [RQ10] optional eight-bit per-channel delay adjust, separate for lead and trail
// [RQ11] hits arriving while the buffer is full are discarded
// [RQ12] hit into the last free slot is stored flagged and buffer becomes full
// [RQ13] after four entries freed, next hit clears full and is stored flagged
// [RQ14] each trigger yields a twelve-bit time tag and twelve-bit event number
// [RQ15] tag is a free-running counter sampled at trigger, loaded with offset at reset
// [RQ16] tag and event pairs wait in an eight-entry trigger FIFO
// [RQ17] trigger arriving with trigger FIFO full is dropped and the loss recorded
// [RQ18] once space returns, latest lost event number is written with lost flag
// [RQ19] matching logic emits one empty lost event per missing event number
// [RQ20] hit coarse counter loads a programmable offset at reset
// [RQ21] channel requests arrive already synchronised to this clock
// [RQ22] event counter advances on every trigger, dropped ones included
`default_nettype none
module hbtc_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;
   assign in_ready_o = (count != (AW+1)'(D));
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   always_comb begin
      next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      next_count = count;
      if (push && !pop) begin
         next_count = (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (AW+1)'(count - 1'b1);
      end
   end
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
endmodule : hbtc_fifo

module hbtc_top import hbtc_pkg::*; (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [1:0] mode_i,
   input wire logic adj_en_i,
   input wire logic [NCH*ADJ_W-1:0] adj_lead_i,
   input wire logic [NCH*ADJ_W-1:0] adj_trail_i,
   input wire logic [COARSE_W-1:0] coarse_offset_i,
   input wire logic [TAG_W-1:0] tag_offset_i,
   output logic [COARSE_W-1:0] coarse_count_o,
   input wire logic [NCH-1:0] ch_req_i,
   output logic [NCH-1:0] ch_ack_o,
   input wire logic [NCH-1:0] ch_edge_i,
   input wire logic [NCH*FINE_TAPS-1:0] ch_lead_fine_i,
   input wire logic [NCH*COARSE_W-1:0] ch_lead_c0_i,
   input wire logic [NCH*COARSE_W-1:0] ch_lead_c1_i,
   input wire logic [NCH*FINE_TAPS-1:0] ch_trail_fine_i,
   input wire logic [NCH*COARSE_W-1:0] ch_trail_c0_i,
   input wire logic [NCH*COARSE_W-1:0] ch_trail_c1_i,
   input wire logic l1_hold_i,
   input wire logic [L1_AW-1:0] l1_rd_addr_i,
   output logic [HIT_W-1:0] l1_rd_data_o,
   input wire logic l1_free_i,
   output logic [L1_AW-1:0] l1_wr_ptr_o,
   output logic [L1_CNT_W-1:0] l1_count_o,
   output logic l1_full_o,
   input wire logic trig_i,
   output logic trg_valid_o,
   input wire logic trg_ready_i,
   output logic [TRG_W-1:0] trg_data_o,
   output logic trg_full_o,
   output logic trg_lost_o
);
   function automatic logic [FINE_W-1:0] therm2bin(input logic [FINE_TAPS-1:0] t);
      logic [FINE_W:0] n;
      n = '0;
      for (int i = 1; i < FINE_TAPS; i++) begin
         if (t[i]) n = (FINE_W+1)'(i);
      end
      return n[FINE_W-1:0];
   endfunction

   function automatic logic [TIME_W-1:0] pick_time(input logic [FINE_TAPS-1:0] t,
         input logic [COARSE_W-1:0] c0, input logic [COARSE_W-1:0] c1, input logic [ADJ_W-1:0] adj);
      logic [FINE_W-1:0] f;
      logic [TIME_W-1:0] tm;
      f = therm2bin(t);
      tm = {(f < FINE_HALF) ? c1 : c0, f}; // [RQ6]
      return TIME_W'(tm + TIME_W'(adj)); // [RQ10]
   endfunction

   function automatic logic [WIDTH_W-1:0] sat_w(input logic [TIME_W-1:0] d);
      return (d > TIME_W'(WIDTH_MAX)) ? WIDTH_MAX : d[WIDTH_W-1:0];
   endfunction

   // arbitration queue
   logic [NCH-1:0] queue, next_queue, grant;
   logic [CH_W-1:0] gidx;
   logic hf_ready, hf_valid, hf_pop;
   logic [HIT_W-1:0] hf_din, hf_dout;
   always_comb begin
      grant = '0;
      gidx = '0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (queue[i]) begin
            grant = NCH'(1) << i; // [RQ7]
            gidx = CH_W'(i);
         end
      end
      if (!hf_ready) grant = '0;
      next_queue = (queue == '0) ? ch_req_i : (queue & ~grant); // [RQ7] [RQ8] [RQ9]
   end
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) queue <= QUEUE_RESET;
      else queue <= next_queue;
   end
   assign ch_ack_o = grant;

   // measurement assembly for the granted channel
   logic [TIME_W-1:0] lead_t, trail_t, diff_t;
   logic [WIDTH_W-1:0] width_f;
   logic [ADJ_W-1:0] al, at;
   always_comb begin
      al = adj_en_i ? adj_lead_i[gidx*ADJ_W +: ADJ_W] : '0;
      at = adj_en_i ? adj_trail_i[gidx*ADJ_W +: ADJ_W] : '0;
      lead_t = pick_time(ch_lead_fine_i[gidx*FINE_TAPS +: FINE_TAPS], ch_lead_c0_i[gidx*COARSE_W +: COARSE_W],
            ch_lead_c1_i[gidx*COARSE_W +: COARSE_W], ch_edge_i[gidx] ? at : al);
      trail_t = pick_time(ch_trail_fine_i[gidx*FINE_TAPS +: FINE_TAPS], ch_trail_c0_i[gidx*COARSE_W +: COARSE_W],
            ch_trail_c1_i[gidx*COARSE_W +: COARSE_W], at);
      diff_t = TIME_W'(trail_t - lead_t);
      unique case (hbtc_mode_t'(mode_i))
         HBTC_MODE_SINGLE: begin
            width_f = '0;
            width_f[HW_EDGE_BIT] = ch_edge_i[gidx]; // [RQ3]
         end
         HBTC_MODE_TRAIL: width_f = sat_w(diff_t >> TRAIL_SHIFT); // [RQ5]
         default: width_f = sat_w(diff_t); // [RQ4]
      endcase
      hf_din = {1'b0, gidx, lead_t, width_f}; // [RQ3] [RQ6]
   end

   hbtc_fifo #(.W(HIT_W), .D(HIT_FIFO_DEPTH)) u_hit_fifo (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(grant != '0),
      .in_ready_o(hf_ready),
      .in_data_i(hf_din),
      .out_valid_o(hf_valid),
      .out_ready_i(!l1_hold_i),
      .out_data_o(hf_dout)
   );
   assign hf_pop = hf_valid && !l1_hold_i;

   // first level buffer with overflow marking
   logic [HIT_W-1:0] l1_mem [L1_DEPTH];
   logic [L1_AW-1:0] wr_ptr, next_wr_ptr;
   logic [L1_CNT_W-1:0] count, next_count;
   logic full, next_full, l1_we, recover, last_slot, do_free;
   logic [HIT_W-1:0] l1_wdata, rd_data;
   logic [COARSE_W-1:0] coarse;
   always_comb begin
      recover = full && (count <= L1_CNT_W'(L1_DEPTH - RECOVER_FREE)); // [RQ13]
      last_slot = !full && (count == L1_CNT_W'(L1_DEPTH - 1)); // [RQ12]
      l1_we = hf_pop && (!full || recover); // [RQ11]
      do_free = l1_free_i && (count != '0);
      l1_wdata = hf_dout;
      l1_wdata[HW_OVF_BIT] = last_slot || recover; // [RQ12] [RQ13]
      next_full = full;
      if (l1_we && last_slot) next_full = 1'b1; // [RQ12]
      else if (l1_we && recover) next_full = 1'b0; // [RQ13]
      next_wr_ptr = l1_we ? L1_AW'(wr_ptr + 1'b1) : wr_ptr; // [RQ1]
      next_count = L1_CNT_W'(count + L1_CNT_W'(l1_we) - L1_CNT_W'(do_free));
   end
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         wr_ptr <= '0;
         count <= '0;
         full <= 1'b0;
         coarse <= coarse_offset_i; // [RQ20]
         rd_data <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         count <= next_count;
         full <= next_full;
         coarse <= COARSE_W'(coarse + 1'b1);
         rd_data <= l1_mem[l1_rd_addr_i]; // [RQ2]
      end
      if (l1_we) l1_mem[wr_ptr] <= l1_wdata; // [RQ1]
   end
   assign l1_rd_data_o = rd_data;
   assign l1_wr_ptr_o = wr_ptr;
   assign l1_count_o = count;
   assign l1_full_o = full;
   assign coarse_count_o = coarse;

   // trigger interface
   logic [TAG_W-1:0] tag, next_tag;
   logic [EVT_W-1:0] evt, next_evt, lost_evt, next_lost_evt;
   logic lost, next_lost, tf_ready, tf_we;
   logic [TRG_W-1:0] tf_din;
   always_comb begin
      next_tag = TAG_W'(tag + 1'b1); // [RQ15]
      next_evt = trig_i ? EVT_W'(evt + 1'b1) : evt; // [RQ22]
      next_lost = lost;
      next_lost_evt = lost_evt;
      tf_we = 1'b0;
      tf_din = {1'b0, evt, tag}; // [RQ14] [RQ15]
      if (lost && tf_ready) begin
         tf_we = 1'b1;
         tf_din = {1'b1, lost_evt, tag}; // [RQ18]
         next_lost = 1'b0;
      end else if (trig_i && tf_ready) begin
         tf_we = 1'b1; // [RQ16]
      end
      // arriving trigger that cannot be written is folded into the lost record
      if (trig_i && !(tf_we && !tf_din[TW_LOST_BIT])) begin
         next_lost = 1'b1; // [RQ17]
         next_lost_evt = evt;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         tag <= tag_offset_i; // [RQ15]
         evt <= EVT_RESET;
         lost <= 1'b0;
         lost_evt <= EVT_RESET;
      end else begin
         tag <= next_tag;
         evt <= next_evt;
         lost <= next_lost;
         lost_evt <= next_lost_evt;
      end
   end

   hbtc_fifo #(.W(TRG_W), .D(TRG_FIFO_DEPTH)) u_trg_fifo (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(tf_we),
      .in_ready_o(tf_ready),
      .in_data_i(tf_din),
      .out_valid_o(trg_valid_o),
      .out_ready_i(trg_ready_i),
      .out_data_o(trg_data_o)
   );
   assign trg_full_o = !tf_ready;
   assign trg_lost_o = lost;

   AST_ONE_GRANT: assert property (@(posedge mclk_i) disable iff (sys_rst_i) $onehot0(ch_ack_o)) // [RQ8]
      else $error("more than one channel granted");
   AST_PRIORITY: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RQ7]
      (ch_ack_o != '0) |-> ((ch_ack_o & ~queue) == '0) && (((ch_ack_o - 1'b1) & queue) == '0))
      else $error("grant not lowest queued channel");
   AST_NO_ADMIT: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RQ7]
      (queue != '0) |=> ((queue & ~$past(queue)) == '0))
      else $error("request admitted into busy queue");
   AST_DRAIN: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RQ8]
      (queue != '0 && hf_ready) |=> ($countones(queue) == $countones($past(queue)) - 1))
      else $error("queue not served one per cycle");
   AST_CIRCULAR: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RQ1]
      l1_we |=> (wr_ptr == L1_AW'($past(wr_ptr) + 1'b1)) && (l1_mem[$past(wr_ptr)] == $past(l1_wdata)))
      else $error("hit not written at next location");
   AST_FULL_DROP: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RQ11]
      (full && !recover && hf_pop) |=> $stable(wr_ptr) && full)
      else $error("hit written while buffer full");
   AST_ENTER_FULL: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RQ12]
      (hf_pop && !full && count == L1_CNT_W'(L1_DEPTH - 1)) |=> full && l1_mem[$past(wr_ptr)][HW_OVF_BIT])
      else $error("last slot hit not flagged or full not entered");
   AST_RECOVER: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RQ13]
      (full && hf_pop && count <= L1_CNT_W'(L1_DEPTH - RECOVER_FREE)) |=> !full && l1_mem[$past(wr_ptr)][HW_OVF_BIT])
      else $error("recovery hit not flagged or full not cleared");
   AST_TRG_DROP: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RQ17]
      (trig_i && !tf_ready) |=> lost && lost_evt == $past(evt))
      else $error("lost trigger not recorded");
   AST_LOST_ENTRY: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RQ18]
      (lost && tf_ready) |-> tf_we && tf_din[TW_LOST_BIT] && tf_din[TW_EVT_LSB +: EVT_W] == lost_evt)
      else $error("lost entry not written when space returned");
   AST_EVT_STEP: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RQ22]
      trig_i |=> evt == EVT_W'($past(evt) + 1'b1))
      else $error("event number did not advance");
   AST_TAG_RUN: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [RQ15]
      !$past(sys_rst_i) |-> (tag == TAG_W'($past(tag) + 1'b1)))
      else $error("time tag counter not free running");
endmodule : hbtc_top
`default_nettype wire

// >>> dv/hbtc_chan_model.sv
`default_nettype none
module hbtc_chan_model import hbtc_pkg::*; (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [NCH-1:0] post_i,
   input wire logic [NCH-1:0] edge_sel_i,
   input wire logic [NCH-1:0] ch_ack_i,
   output logic [NCH-1:0] ch_req_o,
   output logic [NCH-1:0] ch_edge_o,
   output logic [NCH*FINE_TAPS-1:0] lead_fine_o,
   output logic [NCH*COARSE_W-1:0] lead_c0_o,
   output logic [NCH*COARSE_W-1:0] lead_c1_o,
   output logic [NCH*FINE_TAPS-1:0] trail_fine_o,
   output logic [NCH*COARSE_W-1:0] trail_c0_o,
   output logic [NCH*COARSE_W-1:0] trail_c1_o
);
   logic [FINE_TAPS-1:0] th;
   logic [COARSE_W-1:0] iv;
   // raise with a finished pulse only, drop at the edge after the ack
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ch_req_o <= '0;
      end else begin
         ch_req_o <= (ch_req_o & ~ch_ack_i) | post_i;
      end
   end
   // fine bin n, trailing edge two ticks later; idle lines inverted
   always_comb begin
      th = '0;
      iv = '0;
      for (int n = 0; n < NCH; n++) begin
         iv = {COARSE_W{~ch_req_o[n]}};
         th = FINE_TAPS'((33'h1 << (n + 1)) - 33'h1) ^ {FINE_TAPS{~ch_req_o[n]}};
         lead_fine_o[n*FINE_TAPS+:FINE_TAPS] = th;
         trail_fine_o[n*FINE_TAPS+:FINE_TAPS] = th;
         lead_c0_o[n*COARSE_W+:COARSE_W] = COARSE_W'(12'h100 + n) ^ iv;
         lead_c1_o[n*COARSE_W+:COARSE_W] = COARSE_W'(12'h200 + n) ^ iv;
         trail_c0_o[n*COARSE_W+:COARSE_W] = COARSE_W'(12'h102 + n) ^ iv;
         trail_c1_o[n*COARSE_W+:COARSE_W] = COARSE_W'(12'h202 + n) ^ iv;
         ch_edge_o[n] = edge_sel_i[n] ^ ~ch_req_o[n];
      end
   end
endmodule // hbtc_chan_model
`default_nettype wire

// >>> dv/test_hbtc_top.sv
`default_nettype none
module test_hbtc_top import hbtc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [COARSE_W-1:0] COFF = 12'h123;
   localparam logic [TAG_W-1:0] TOFF = 12'h0F0;
   localparam logic [31:0] OVF = 32'h40000000;
   logic mclk, rst = 1'b1, adj_en = 1'b0, hold = 1'b0, free = 1'b0, trig = 1'b0, trg_ready = 1'b0;
   hbtc_mode_t mode = HBTC_MODE_CHARGE;
   logic [L1_AW-1:0] rd_addr = '0, exp_wp = '0, wr_ptr;
   logic [L1_CNT_W-1:0] cnt, exp_cnt = '0;
   logic [NCH-1:0] post = '0, edge_sel = '0, req, edg, ack;
   logic [NCH*FINE_TAPS-1:0] lf, tf;
   logic [NCH*COARSE_W-1:0] lc0, lc1, tc0, tc1;
   logic [COARSE_W-1:0] coarse, cyc;
   logic [HIT_W-1:0] rd_data;
   logic [TRG_W-1:0] trg_data;
   logic l1_full, trg_valid, trg_full, trg_lost;
   logic [NCH-1:0] ackq[$];
   int ackt[$];
   int n_fail = 0, n_tests = 0, tick = 0;
   logic [31:0] d;
   hbtc_top hbtc_top_inst (.mclk_i(mclk), .sys_rst_i(rst), .mode_i(mode), .adj_en_i(adj_en),
      .adj_lead_i({NCH{8'h11}}), .adj_trail_i({NCH{8'h22}}), .coarse_offset_i(COFF), .tag_offset_i(TOFF),
      .coarse_count_o(coarse), .ch_req_i(req), .ch_ack_o(ack), .ch_edge_i(edg), .ch_lead_fine_i(lf),
      .ch_lead_c0_i(lc0), .ch_lead_c1_i(lc1), .ch_trail_fine_i(tf), .ch_trail_c0_i(tc0), .ch_trail_c1_i(tc1),
      .l1_hold_i(hold), .l1_rd_addr_i(rd_addr), .l1_rd_data_o(rd_data), .l1_free_i(free), .l1_wr_ptr_o(wr_ptr),
      .l1_count_o(cnt), .l1_full_o(l1_full), .trig_i(trig), .trg_valid_o(trg_valid), .trg_ready_i(trg_ready),
      .trg_data_o(trg_data), .trg_full_o(trg_full), .trg_lost_o(trg_lost));
   hbtc_chan_model hbtc_chan_model_inst (.mclk_i(mclk), .sys_rst_i(rst), .post_i(post), .edge_sel_i(edge_sel),
      .ch_ack_i(ack), .ch_req_o(req), .ch_edge_o(edg), .lead_fine_o(lf), .lead_c0_o(lc0), .lead_c1_o(lc1),
      .trail_fine_o(tf), .trail_c0_o(tc0), .trail_c1_o(tc1));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= rst ? '0 : cyc + 12'h001;
      tick <= tick + 1;
      if (tick == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   always @(negedge mclk) begin
      if (ack !== '0) begin
         ackq.push_back(ack);
         ackt.push_back(tick);
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   function automatic logic [31:0] exp_word(input int ch, input hbtc_mode_t m, input logic e, input logic a);
      logic [TIME_W-1:0] t;
      logic [WIDTH_W-1:0] wd;
      t = {(ch < 16) ? COARSE_W'(12'h200 + ch) : COARSE_W'(12'h100 + ch), FINE_W'(ch)};
      t = t + (a ? TIME_W'(e ? 8'h22 : 8'h11) : TIME_W'(0));
      wd = (m == HBTC_MODE_TRAIL) ? 8'h08 : (m == HBTC_MODE_SINGLE) ? {7'h00, e} : 8'h40;
      return {2'b00, CH_W'(ch), t, wd};
   endfunction
   task automatic post_hits(input logic [NCH-1:0] m);
      @(posedge mclk);
      post <= m;
      @(posedge mclk);
      post <= '0;
   endtask
   task automatic free_one();
      @(posedge mclk);
      free <= 1'b1;
      @(posedge mclk);
      free <= 1'b0;
   endtask
   task automatic rd(input logic [L1_AW-1:0] a);
      @(posedge mclk);
      rd_addr <= a;
      @(posedge mclk);
      @(negedge mclk);
      d = 32'(rd_data);
   endtask
   task automatic wait_cnt(input int n);
      exp_cnt = exp_cnt + L1_CNT_W'(n);
      for (int i = 0; i < 300 && cnt !== exp_cnt; i++) @(negedge mclk);
      check(cnt, exp_cnt);
   endtask
   task automatic pop();
      @(posedge mclk);
      trg_ready <= 1'b1;
      @(negedge mclk);
      for (int i = 0; i < 50 && trg_valid !== 1'b1; i++) @(negedge mclk);
      d = 32'(trg_data);
      @(posedge mclk);
      trg_ready <= 1'b0;
   endtask
   task automatic fire(output logic [TAG_W-1:0] t);
      @(posedge mclk);
      trig <= 1'b1;
      @(negedge mclk);
      t = TAG_W'(TOFF + cyc);
      @(posedge mclk);
      trig <= 1'b0;
   endtask
   task automatic t_reset();
      @(negedge mclk);
      check({l1_full, trg_valid, trg_lost}, 0);
      check(ack, 0);
      check({wr_ptr, cnt}, 0);
      repeat (5) @(negedge mclk);
      check(coarse, COARSE_W'(COFF + cyc));
   endtask
   task automatic one_hit(input int ch, input hbtc_mode_t m, input logic e);
      logic s;
      s = (m == HBTC_MODE_SINGLE);
      @(posedge mclk);
      mode <= m;
      adj_en <= s;
      edge_sel <= NCH'(e) << ch;
      post_hits(NCH'(1) << ch);
      wait_cnt(1);
      rd(exp_wp);
      exp_wp++;
      check(d & (s ? 32'hFFFFFF01 : 32'hFFFFFFFF), exp_word(ch, m, e, s));
   endtask
   task automatic t_arb();
      int ord[4] = '{2, 5, 9, 0};
      one_hit(0, HBTC_MODE_CHARGE, 1'b0);
      ackq.delete();
      ackt.delete();
      post_hits(24'h000224);
      for (int i = 0; i < 50 && ackq.size() == 0; i++) @(negedge mclk);
      post_hits(24'h000001);
      wait_cnt(4);
      check(ackt[2] - ackt[0], 2);
      for (int i = 0; i < 4; i++) check(ackq[i], NCH'(1) << ord[i]);
      for (int i = 3; i >= 0; i--) begin
         rd(exp_wp + L1_AW'(i));
         check(d, exp_word(ord[i], HBTC_MODE_CHARGE, 1'b0, 1'b0));
      end
      exp_wp += 4;
   endtask
   task automatic t_buf();
      @(posedge mclk);
      hold <= 1'b1;
      ackq.delete();
      post_hits('1);
      repeat (40) @(negedge mclk);
      check(ackq.size(), 16);
      check(cnt, exp_cnt);
      @(posedge mclk);
      hold <= 1'b0;
      wait_cnt(24);
      check(ackq.size(), 24);
      exp_wp += 24;
   endtask
   task automatic t_ovf();
      int k;
      while (exp_cnt + 24 <= 127) begin
         post_hits('1);
         wait_cnt(24);
         exp_wp += 24;
      end
      k = 127 - exp_cnt;
      post_hits('1);
      wait_cnt(k + 1);
      exp_wp += k + 1;
      repeat (30) @(negedge mclk);
      check({l1_full, cnt, wr_ptr}, {1'b1, 8'h80, exp_wp});
      rd(exp_wp - 7'h01);
      check(d, exp_word(k, HBTC_MODE_CHARGE, 1'b0, 1'b0) | OVF);
      rd(exp_wp - 7'h02);
      check(d, exp_word(k - 1, HBTC_MODE_CHARGE, 1'b0, 1'b0));
      repeat (3) free_one();
      post_hits(24'h000080);
      repeat (20) @(negedge mclk);
      check({l1_full, cnt}, {1'b1, 8'h7D});
      free_one();
      exp_cnt = exp_cnt - 8'h04;
      post_hits(24'h000100);
      wait_cnt(1);
      rd(exp_wp);
      check(l1_full, 1'b0);
      check(d, exp_word(8, HBTC_MODE_CHARGE, 1'b0, 1'b0) | OVF);
   endtask
   task automatic t_trig();
      logic [TAG_W-1:0] tg[12];
      for (int i = 0; i < 11; i++) fire(tg[i]);
      @(negedge mclk);
      check({trg_full, trg_lost}, 2'b11);
      for (int i = 0; i < 8; i++) begin
         pop();
         check(d, {1'b0, EVT_W'(i), tg[i]});
      end
      pop();
      check(trg_lost, 1'b0);
      check(d & 32'h01FFF000, 32'h0100A000);
      fire(tg[11]);
      pop();
      check(d, {1'b0, 12'h00B, tg[11]});
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      one_hit(20, HBTC_MODE_SINGLE, 1'b1);
      one_hit(3, HBTC_MODE_SINGLE, 1'b0);
      one_hit(20, HBTC_MODE_TRAIL, 1'b0);
      one_hit(3, HBTC_MODE_TRAIL, 1'b0);
      // spare mode code behaves as charge
      one_hit(5, hbtc_mode_t'(2'b11), 1'b0);
      t_arb();
      t_buf();
      t_ovf();
      t_trig();
      report_and_stop();
   end
endmodule // test_hbtc_top
`default_nettype wire
